//--- rtl/can_master_status_pkg.sv
// Constants, field layout and carrier types for the CAN master status block.
// Assumes a 32-bit Avalon-MM register bus with word addressing by byte.
package can_master_status_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] OffMasterStatus = 4'h0;
  localparam logic [3:0] OffSleepControl = 4'h4;
  localparam logic [3:0] OffIrqEnable    = 4'h8;
  localparam logic [3:0] OffErrorStatus  = 4'hC;

  // ****************************************************************
  // Master status fields
  // ****************************************************************
  localparam int BitLiveRx     = 11;
  localparam int BitSampledRx  = 10;
  localparam int BitRxBusy     = 9;
  localparam int BitTxBusy     = 8;
  localparam int BitSleepEnter = 4;
  localparam int BitSleepExit  = 3;
  localparam int BitError      = 2;
  localparam int BitSleepAck   = 1;

  // Interrupt enable register fields.
  localparam int BitEnSleepEnter = 0;
  localparam int BitEnSleepExit  = 1;
  localparam int BitEnError      = 2;
  localparam int BitEnErrSources = 8;
  localparam int ErrSourceCount  = 3;

  // Sleep control register fields.
  localparam int BitSleepRequest  = 0;
  localparam int BitAutoSleepExit = 1;

  localparam logic [31:0] ReadZero      = 32'h0000_0000;
  localparam logic        RxResetLevel  = 1'h1;
  localparam logic        SleepReqReset = 1'h1;
  localparam int          RecessiveRun  = 11;
  localparam logic [3:0]  RunMax        = 4'hA;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } bus_req_t;

  typedef struct packed {
    logic        rxFrameStart;
    logic        rxFrameEnd;
    logic        txFrameStart;
    logic        txFrameEnd;
    logic        bitTick;
    logic        startOfFrame;
    logic [2:0]  errorEvent;
  } link_evt_t;

  typedef enum logic [1:0] {
    Awake,
    Draining,
    Asleep
  } sleep_state_t;

endpackage : can_master_status_pkg

//--- rtl/w1c_flag.sv
// One sticky status flag, set by hardware and cleared by writing one.
// Assumes set and clear come from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module w1c_flag (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic setEvt,
  input  wire logic clrEvt,
  output var  logic flag
);
  logic flag_nxt;

  // Set wins over clear so no event is lost in the clearing cycle.
  assign flag_nxt = setEvt | (flag & ~clrEvt);

  always_ff @(posedge core_clk) begin
    if (!rst_n) flag <= 1'b0;
    else        flag <= flag_nxt;
  end
endmodule : w1c_flag
`default_nettype wire

//--- rtl/can_master_status.sv
// Master status register of a CAN controller with its sleep handshake.
// Assumes a 100 MHz core_clk, an Avalon-MM slave port, and frame and bit
// events delivered by the protocol engine synchronous to core_clk.
// Operation
// - Bits 31 to 12 and 7 to 5 of the master status register read zero.
// - Bit 11 shows the live receive pin level and resets to one.
// - Bit 10 shows the last sampled receive level and resets to one.
// - Bit 9 is set when a reception starts and cleared when it ends.
// - Bit 8 is set when a transmission starts and cleared when it ends.
// - Bit 4 is set on sleep entry only if its enable is one and interrupts.
// - Bit 4 clears on a write of one or when the sleep acknowledge clears.
// - Bit 3 is set when sleep is left, and on a start of frame while asleep with auto exit set.
// - Bit 3 raises the status interrupt when its enable is set; W1C.
// - Bit 2 is set when an enabled error source fires; W1C.
// - Bit 2 raises the status interrupt when its enable is one.
// - Bit 1 sets after activity ends and clears after 11 recessive bits.
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module can_master_status
  import can_master_status_pkg::*;
#(
  parameter int ErrSources = ErrSourceCount
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        rxPin,
  input  wire link_evt_t   linkEvt,
  output var  logic        statusChangeIrq,
  output var  logic        sleepAck
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // One wait state: the request is taken on the edge where waitrequest is
  // low, which keeps read data registered and the output flop-driven.
  logic     ack_r;
  bus_req_t req;
  assign req = '{read: avs_read, write: avs_write,
                 address: avs_address, writedata: avs_writedata};

  wire access  = (req.read | req.write) & ~ack_r;
  wire wrTaken = req.write & ack_r;
  wire selMst  = (req.address == OffMasterStatus);
  wire selCtl  = (req.address == OffSleepControl);
  wire selIen  = (req.address == OffIrqEnable);
  wire selEst  = (req.address == OffErrorStatus);
  wire wrMst   = wrTaken & selMst;
  wire wrCtl   = wrTaken & selCtl;
  wire wrIen   = wrTaken & selIen;
  wire wrEst   = wrTaken & selEst;

  always_ff @(posedge core_clk) begin
    if (!rst_n) ack_r <= 1'b0;
    else        ack_r <= access;
  end

  // ****************************************************************
  // Control and error status registers
  // ****************************************************************
  logic                  sleepReq_r;
  logic                  autoExit_r;
  logic [2:0]            ienBase_r;
  logic [ErrSources-1:0] ienErr_r;
  logic [ErrSources-1:0] errStat_r;
  wire                   sleepExitEvt;

  // The request resets set, so the controller comes up asleep and software
  // must clear it before the node can take part on the bus. A start of
  // frame seen while asleep with auto exit set drops the request, so that
  // wake then runs the same recessive count as a software wake.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sleepReq_r <= SleepReqReset;
      autoExit_r <= 1'b0;
    end else if (wrCtl) begin
      sleepReq_r <= req.writedata[BitSleepRequest];
      autoExit_r <= req.writedata[BitAutoSleepExit];
    end else if (sleepExitEvt) begin
      sleepReq_r <= 1'b0;
    end
  end

  // Enables act from the clock after the write, so a flag that is already
  // set raises the interrupt as soon as its enable is written.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ienBase_r <= '0;
      ienErr_r  <= '0;
    end else if (wrIen) begin
      ienBase_r <= req.writedata[BitEnError:BitEnSleepEnter];
      ienErr_r  <= req.writedata[BitEnErrSources +: ErrSources];
    end
  end

  // Error status bits are sticky; set wins over a write-one clear.
  wire [ErrSources-1:0] errClr = wrEst
      ? req.writedata[ErrSources-1:0] : '0;
  wire [ErrSources-1:0] errStat_nxt = linkEvt.errorEvent[ErrSources-1:0]
      | (errStat_r & ~errClr);

  always_ff @(posedge core_clk) begin
    if (!rst_n) errStat_r <= '0;
    else        errStat_r <= errStat_nxt;
  end

  // ****************************************************************
  // Receive pin and activity
  // ****************************************************************
  logic liveRx_r;
  logic sampledRx_r;
  logic rxBusy_r;
  logic txBusy_r;

  // Both pin bits are registered so the read word is built from flops only;
  // the live bit therefore lags the pin by one clock.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      liveRx_r    <= RxResetLevel;
      sampledRx_r <= RxResetLevel;
    end else begin
      liveRx_r <= rxPin;
      if (linkEvt.bitTick) sampledRx_r <= rxPin;
    end
  end

  wire rxBusy_nxt = linkEvt.rxFrameStart
      | (rxBusy_r & ~linkEvt.rxFrameEnd);
  wire txBusy_nxt = linkEvt.txFrameStart
      | (txBusy_r & ~linkEvt.txFrameEnd);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxBusy_r <= 1'b0;
      txBusy_r <= 1'b0;
    end else begin
      rxBusy_r <= rxBusy_nxt;
      txBusy_r <= txBusy_nxt;
    end
  end

  // ****************************************************************
  // Sleep handshake
  // ****************************************************************
  // Entry waits for the link to go idle; leaving needs a run of recessive
  // bits so the node never wakes in the middle of someone else's frame.
  sleep_state_t state_r;
  sleep_state_t state_nxt;
  logic [3:0]   run_r;
  logic [3:0]   run_nxt;

  wire busy         = rxBusy_r | txBusy_r;
  assign sleepExitEvt = (state_r == Asleep) & autoExit_r
      & linkEvt.startOfFrame;
  wire runDone      = linkEvt.bitTick & rxPin & (run_r == RunMax);
  // Entry is judged on the state really taken, so a request withdrawn in
  // the cycle that activity ends does not raise the entry flag.
  wire enterEvt     = (state_r == Draining)
      & (state_nxt == Asleep);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      Awake:    if (sleepReq_r) state_nxt = Draining;
      Draining: begin
        if (!sleepReq_r)  state_nxt = Awake;
        else if (!busy)   state_nxt = Asleep;
      end
      Asleep:   if (!sleepReq_r && runDone) state_nxt = Awake;
    endcase
  end

  // The run restarts on every dominant bit and is held at zero while a
  // sleep request stands, so only an unbroken recessive stretch wakes.
  always_comb begin
    run_nxt = run_r;
    if (state_r != Asleep || sleepReq_r) run_nxt = '0;
    else if (linkEvt.bitTick) run_nxt = rxPin ? run_r + 4'h1 : '0;
  end

  wire leaveEvt = (state_r == Asleep) & (state_nxt == Awake);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r  <= Asleep;
      run_r    <= '0;
      sleepAck <= 1'b1;
    end else begin
      state_r  <= state_nxt;
      run_r    <= run_nxt;
      sleepAck <= (state_nxt == Asleep);
    end
  end

  // ****************************************************************
  // Sticky flags
  // ****************************************************************
  // Writes of zero, and writes to read-only bits, change nothing.
  wire clrEnter = wrMst & req.writedata[BitSleepEnter];
  wire clrExit  = wrMst & req.writedata[BitSleepExit];
  wire clrErr   = wrMst & req.writedata[BitError];

  wire setEnter = enterEvt & ienBase_r[BitEnSleepEnter];
  wire setExit  = leaveEvt | sleepExitEvt;
  // The error flag is re-armed every cycle an enabled source is pending, so
  // a clear only sticks once that error status bit is cleared as well.
  wire setErr   = |(errStat_r & ienErr_r);
  wire ackFall  = leaveEvt;
  logic fEnter;
  logic fExit;
  logic fErr;

  w1c_flag u_enter (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .setEvt   (setEnter),
    .clrEvt   (clrEnter | ackFall),
    .flag     (fEnter)
  );

  w1c_flag u_exit (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .setEvt   (setExit),
    .clrEvt   (clrExit),
    .flag     (fExit)
  );

  w1c_flag u_err (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .setEvt   (setErr),
    .clrEvt   (clrErr),
    .flag     (fErr)
  );

  // The interrupt is a registered level: it follows flags and enables one
  // clock late and drops once software has cleared every cause.
  wire irq_nxt = (fEnter & ienBase_r[BitEnSleepEnter])
      | (fExit & ienBase_r[BitEnSleepExit])
      | (fErr & ienBase_r[BitEnError]);

  always_ff @(posedge core_clk) begin
    if (!rst_n) statusChangeIrq <= 1'b0;
    else        statusChangeIrq <= irq_nxt;
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // The word is rebuilt every cycle and captured once per read, so software
  // sees one coherent snapshot of all status bits.
  logic [31:0] mstWord;
  always_comb begin
    mstWord = ReadZero;
    mstWord[BitLiveRx]     = liveRx_r;
    mstWord[BitSampledRx]  = sampledRx_r;
    mstWord[BitRxBusy]     = rxBusy_r;
    mstWord[BitTxBusy]     = txBusy_r;
    mstWord[BitSleepEnter] = fEnter;
    mstWord[BitSleepExit]  = fExit;
    mstWord[BitError]      = fErr;
    mstWord[BitSleepAck]   = sleepAck;
  end

  logic [31:0] ctlWord;
  logic [31:0] ienWord;
  logic [31:0] estWord;
  always_comb begin
    ctlWord = ReadZero;
    ctlWord[BitSleepRequest]  = sleepReq_r;
    ctlWord[BitAutoSleepExit] = autoExit_r;
    ienWord = ReadZero;
    ienWord[BitEnError:BitEnSleepEnter] = ienBase_r;
    ienWord[BitEnErrSources +: ErrSources] = ienErr_r;
    estWord = ReadZero;
    estWord[ErrSources-1:0] = errStat_r;
  end

  // Unmapped addresses read as zero and ignore writes.
  wire [31:0] rdSel = selMst ? mstWord
                    : selCtl ? ctlWord
                    : selIen ? ienWord
                    : selEst ? estWord : ReadZero;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_readdata    <= ReadZero;
      avs_waitrequest <= 1'b1;
    end else begin
      if (access && req.read) avs_readdata <= rdSel;
      avs_waitrequest <= ~access;
    end
  end

endmodule : can_master_status
`default_nettype wire

//--- test/can_master_status_chk.sv
// Port-level assertions for the CAN master status block.
// Assumes it is bound into can_master_status and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module can_master_status_chk
  import can_master_status_pkg::*;
#(
  parameter int ErrSources = ErrSourceCount
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic        rxPin,
  input  wire link_evt_t   linkEvt,
  input  wire logic        statusChangeIrq,
  input  wire logic        sleepAck
);
  // ****************************************************************
  // Reference state
  // ****************************************************************
  logic       rxBusy_r;
  logic       txBusy_r;
  logic       sampled_r;
  logic       prevRx_r;
  logic [3:0] runCnt_r;
  logic [1:0] quiet_r;
  wire logic  stRd = avs_read && !avs_waitrequest && avs_address == 4'h0;
  wire logic  frameEvt = linkEvt.rxFrameStart || linkEvt.rxFrameEnd
                      || linkEvt.txFrameStart || linkEvt.txFrameEnd;

  // Pin and busy bits of a read are only judged once pin and frame events have settled, since
  // the design's read path latency is not visible at the ports.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxBusy_r  <= 1'h0;
      txBusy_r  <= 1'h0;
      sampled_r <= 1'h1;
      prevRx_r  <= 1'h1;
      runCnt_r  <= 4'h0;
      quiet_r   <= 2'h0;
    end else begin
      rxBusy_r <= linkEvt.rxFrameStart || (rxBusy_r && !linkEvt.rxFrameEnd);
      txBusy_r <= linkEvt.txFrameStart || (txBusy_r && !linkEvt.txFrameEnd);
      prevRx_r <= rxPin;
      if (linkEvt.bitTick) begin
        sampled_r <= rxPin;
        runCnt_r  <= !rxPin ? 4'h0 : runCnt_r + {3'h0, runCnt_r != 4'hF};
      end
      quiet_r <= (frameEvt || rxPin != prevRx_r) ? 2'h0
               : quiet_r + {1'h0, quiet_r != 2'h3};
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  wait_answer_a: assert property
    ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
    else $error("request not answered");
  wait_single_a: assert property
    (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  reserved_zero_a: assert property
    (stRd |-> avs_readdata[31:12] == 20'h0 && avs_readdata[7:5] == 3'h0)
    else $error("reserved status bits not zero");
  live_rx_a: assert property
    (stRd && quiet_r == 2'h3 |-> avs_readdata[11] == rxPin)
    else $error("live pin level wrong");
  sampled_rx_a: assert property
    (stRd && quiet_r == 2'h3 && !$past(linkEvt.bitTick)
      && !$past(linkEvt.bitTick, 2) |-> avs_readdata[10] == sampled_r)
    else $error("sampled pin level wrong");
  rx_busy_a: assert property
    (stRd && quiet_r == 2'h3 |-> avs_readdata[9] == rxBusy_r)
    else $error("receive busy bit wrong");
  tx_busy_a: assert property
    (stRd && quiet_r == 2'h3 |-> avs_readdata[8] == txBusy_r)
    else $error("transmit busy bit wrong");
  ack_idle_a: assert property
    ($rose(sleepAck) |-> !rxBusy_r && !txBusy_r)
    else $error("sleep entered during activity");
  ack_run_a: assert property
    ($fell(sleepAck) |-> runCnt_r >= 4'hB)
    else $error("sleep left too early");

  enter_c: cover property ($rose(sleepAck));
  wake_c: cover property ($fell(sleepAck));
  irq_c: cover property ($rose(statusChangeIrq));
endmodule : can_master_status_chk

bind can_master_status can_master_status_chk #(.ErrSources(ErrSources))
  u_can_master_status_chk (.core_clk(core_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rxPin(rxPin), .linkEvt(linkEvt),
  .statusChangeIrq(statusChangeIrq), .sleepAck(sleepAck));
`default_nettype wire

//--- test/can_bus_node_model.sv
// Stand-in for the other CAN nodes seen through the transceiver.
// Assumes the bench commands bus level and frame events.
`timescale 1ns/1ns
`default_nettype none
module can_bus_node_model
  import can_master_status_pkg::*;
#(
  parameter int TickDiv = 4
) (
  input  wire logic      core_clk,
  input  wire logic      rst_n,
  input  wire logic      dominant,
  input  wire link_evt_t evtCmd,
  output var  logic      rxPin,
  output var  link_evt_t linkEvt
);
  // ****************************************************************
  // Bit timing
  // ****************************************************************
  logic [3:0] divCnt_r;

  // The bit clock runs free because bit timing keeps sampling an idle bus.
  always_ff @(posedge core_clk) begin
    if (!rst_n || divCnt_r == 4'(TickDiv - 1)) begin
      divCnt_r <= 4'h0;
    end else begin
      divCnt_r <= divCnt_r + 4'h1;
    end
  end

  always_comb begin
    linkEvt         = evtCmd;
    linkEvt.bitTick = rst_n && divCnt_r == 4'h0;
  end

  // An undriven bus is recessive, so the pin idles high.
  assign rxPin = !dominant;
endmodule : can_bus_node_model
`default_nettype wire

//--- test/can_master_status_tb_top.sv
// Self-checking bench for the CAN master status block.
// Assumes the node model supplies the pin and the link events.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin cmpCount++; if ((got) !== (exp)) begin \
  fails++; $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module can_master_status_tb_top
  import can_master_status_pkg::*;
;
  // ****************************************************************
  // Bench
  // ****************************************************************
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        dom = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] got;
  logic        waitReq;
  logic        irq;
  logic        ack;
  logic        rxPin;
  link_evt_t   evtCmd = '0;
  link_evt_t   linkEvt;
  int          fails = 0;
  int          cmpCount = 0;

  always #5 core_clk = ~core_clk;

  can_master_status u_can_master_status (.core_clk(core_clk),
    .rst_n(rst_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(waitReq), .rxPin(rxPin), .linkEvt(linkEvt),
    .statusChangeIrq(irq), .sleepAck(ack));
  can_bus_node_model u_can_bus_node_model (.core_clk(core_clk),
    .rst_n(rst_n), .dominant(dom), .evtCmd(evtCmd), .rxPin(rxPin),
    .linkEvt(linkEvt));

  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge core_clk);
    end while (waitReq !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc

  task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    `CHK("readdata", e, got)
  endtask : rdChk

  task automatic waitAck(input logic v);
    int n;
    n = 0;
    while (ack !== v && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    `CHK("sleepAck", v, ack)
  endtask : waitAck

  task automatic irqIs(input logic v);
    repeat (3) @(posedge core_clk);
    `CHK("irq", v, irq)
  endtask : irqIs

  // Event bits: 100 rx start, 080 rx end, 040 tx start, 020 tx end,
  // 008 start of frame, 007 error sources.
  task automatic pulse(input logic [8:0] e);
    @(posedge core_clk);
    evtCmd <= link_evt_t'(e);
    @(posedge core_clk);
    evtCmd <= '0;
  endtask : pulse

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rdChk(4'h0, 32'hC02);
    `CHK("sleepAck", 1'b1, ack)
    acc(1'b1, 4'h0, 32'hFFFFFFFF);
    rdChk(4'h0, 32'hC02);
    acc(1'b1, 4'h2, 32'hFFFFFFFF);
    rdChk(4'h2, 32'h0);
    $display("test reset done");
    acc(1'b1, 4'h8, 32'h2);
    acc(1'b1, 4'h4, 32'h0);
    repeat (20) @(posedge core_clk);
    `CHK("sleepAck", 1'b1, ack)
    waitAck(1'b0);
    rdChk(4'h0, 32'hC08);
    irqIs(1'b1);
    acc(1'b1, 4'h0, 32'h0);
    rdChk(4'h0, 32'hC08);
    acc(1'b1, 4'h0, 32'h8);
    rdChk(4'h0, 32'hC00);
    irqIs(1'b0);
    $display("test wake done");
    for (int i = 0; i < 2; i++) begin
      pulse(i ? 9'h040 : 9'h100);
      rdChk(4'h0, i ? 32'hD00 : 32'hE00);
      pulse(i ? 9'h020 : 9'h080);
      rdChk(4'h0, 32'hC00);
    end
    dom <= 1'b1;
    repeat (10) @(posedge core_clk);
    rdChk(4'h0, 32'h0);
    dom <= 1'b0;
    repeat (10) @(posedge core_clk);
    rdChk(4'h0, 32'hC00);
    $display("test activity done");
    acc(1'b1, 4'h8, 32'h104);
    pulse(9'h002);
    rdChk(4'h0, 32'hC00);
    pulse(9'h001);
    rdChk(4'h0, 32'hC04);
    irqIs(1'b1);
    acc(1'b1, 4'hC, 32'h3);
    acc(1'b1, 4'h0, 32'h4);
    rdChk(4'h0, 32'hC00);
    irqIs(1'b0);
    $display("test error done");
    acc(1'b1, 4'h8, 32'h1);
    pulse(9'h100);
    acc(1'b1, 4'h4, 32'h1);
    repeat (20) @(posedge core_clk);
    `CHK("sleepAck", 1'b0, ack)
    fork
      acc(1'b1, 4'h4, 32'h0);
      begin
        repeat (2) @(posedge core_clk);
        evtCmd <= link_evt_t'(9'h080);
        @(posedge core_clk);
        evtCmd <= '0;
      end
    join
    rdChk(4'h0, 32'hC00);
    pulse(9'h100);
    acc(1'b1, 4'h4, 32'h1);
    pulse(9'h080);
    waitAck(1'b1);
    rdChk(4'h0, 32'hC12);
    irqIs(1'b1);
    acc(1'b1, 4'h4, 32'h0);
    waitAck(1'b0);
    rdChk(4'h0, 32'hC08);
    acc(1'b1, 4'h0, 32'h8);
    acc(1'b1, 4'h4, 32'h3);
    waitAck(1'b1);
    acc(1'b1, 4'h0, 32'h10);
    rdChk(4'h0, 32'hC02);
    irqIs(1'b0);
    pulse(9'h008);
    waitAck(1'b0);
    rdChk(4'h0, 32'hC08);
    $display("test sleep done");
    wrap_up();
  end

  // The tests take a few hundred cycles; twenty thousand means a hang.
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
endmodule : can_master_status_tb_top
`default_nettype wire
